// ### i2cra_pkg.sv
// Shared constants for the two-wire controller register interface
package i2cra_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_OWN_ADDR = 8'hc8;
  localparam logic [7:0] OFS_EXT_ADDR = 8'hcc;
  localparam logic [7:0] OFS_BYTE_BUF = 8'hd0;
  localparam logic [7:0] OFS_CONTROL = 8'hd4;
  localparam logic [7:0] OFS_STATUS = 8'hd8;
  localparam logic [7:0] OFS_DIVIDER = 8'hdc;
  localparam logic [7:0] OFS_SOFT_RST = 8'he0;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] STAT_IDLE = 8'hf8;
  // Status codes for slave entry
  localparam logic [7:0] STAT_SLV_WR = 8'h60;
  localparam logic [7:0] STAT_SLV_RD = 8'ha8;
  localparam logic [7:0] STAT_GCALL = 8'h70;
  // Control bit positions
  localparam int CTL_EVENT = 3;
  localparam int CTL_STOP = 4;
  localparam int CTL_START = 5;
  // Own address field positions
  localparam int OA_GCALL = 0;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {I2CRA_IDLE, I2CRA_TEN_WAIT, I2CRA_SLAVE} i2cra_state_t;
endpackage

// ### i2cra_addr_match.sv
// Own-address comparator for one received address byte
`timescale 1ns/1ns
`default_nettype none
module i2cra_addr_match
  import i2cra_pkg::*;
(
  // Programmed addresses
  input wire logic [7:0] own_address_reg,
  input wire logic [7:0] extended_address_reg,
  // Received byte, first bit on the bus in bit 7
  input wire logic [7:0] rx_byte,
  // Match results
  output logic ten_bit,
  output logic match_first,
  output logic match_second,
  output logic match_gcall
);
  // Bit 7 of the own address meets the first bus bit
  always_comb begin
    ten_bit = (own_address_reg[7:3] == TEN_BIT_PREFIX);
    match_first = ten_bit ? (rx_byte[7:1] == {TEN_BIT_PREFIX, own_address_reg[2:1]})
                          : (rx_byte[7:1] == own_address_reg[7:1]);
    match_second = (rx_byte == extended_address_reg);
    match_gcall = own_address_reg[OA_GCALL] && (rx_byte == GCALL_ADDR);
  end
endmodule
`default_nettype wire

// ### i2cra_byte_reg.sv
// Byte register with synchronous clear and write strobe
`timescale 1ns/1ns
`default_nettype none
module i2cra_byte_reg
  import i2cra_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic we,
  input wire logic [7:0] wdata,
  // Stored value
  output logic [7:0] value
);
  logic [7:0] value_q;
  logic [7:0] value_d;
  // Next value
  always_comb begin
    value_d = we ? wdata : value_q;
  end
  // Cleared on hardware reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= RST_ZERO;
    end else begin
      value_q <= value_d;
    end
  end
  assign value = value_q;
endmodule
`default_nettype wire

// ### i2cra_regs.sv
// Register set and own-address recognition of the two-wire controller
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module i2cra_regs
  import i2cra_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial side: address byte just received
  input wire logic addr_valid,
  input wire logic addr_after_start,
  input wire logic [7:0] addr_byte,
  // Serial side: decisions
  output logic addr_ack,
  output logic slave_enter,
  output logic slave_read,
  output logic irq,
  // Bus clock divider value for the bit-rate logic
  output logic [7:0] bit_rate_divider
);
  // Write channel holding registers
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_data_q, w_data_d;
  logic w_lane_q, w_lane_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  // Read channel
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // Internal registers
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] div_q, div_d;
  logic ack_q, ack_d;
  logic enter_q, enter_d;
  logic rd_q, rd_d;
  i2cra_state_t state_q, state_d;
  // Decoded write strobes
  logic wr_fire;
  logic we_oa, we_xa, we_bb, we_ctl, we_div, we_srst, wr_hit;
  logic [7:0] own_q, ext_q, buf_q;
  logic ten_bit, m_first, m_second, m_gcall;

  // Payload leaves once both halves held and response slot free
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write address decode; only byte lane 0 carries data
  always_comb begin
    we_oa = 1'b0;
    we_xa = 1'b0;
    we_bb = 1'b0;
    we_ctl = 1'b0;
    we_div = 1'b0;
    we_srst = 1'b0;
    wr_hit = 1'b1;
    if (aw_addr_q == OFS_OWN_ADDR) begin
      we_oa = wr_fire && w_lane_q;
    end else if (aw_addr_q == OFS_EXT_ADDR) begin
      we_xa = wr_fire && w_lane_q;
    end else if (aw_addr_q == OFS_BYTE_BUF) begin
      we_bb = wr_fire && w_lane_q;
    end else if (aw_addr_q == OFS_CONTROL) begin
      we_ctl = wr_fire && w_lane_q;
    end else if (aw_addr_q == OFS_DIVIDER) begin
      we_div = wr_fire && w_lane_q;
    end else if (aw_addr_q == OFS_SOFT_RST) begin
      we_srst = wr_fire;
    end else begin
      wr_hit = 1'b0; // Status is read-only, so writes there fail too
    end
  end

  // Write channel sequencing; address and data taken in either order
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Read decode; write-only registers answer with an error
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if ({s_axi_araddr[7:2], 2'b00} == OFS_OWN_ADDR) begin
        rdata_d = {24'h00_0000, own_q};
      end else if ({s_axi_araddr[7:2], 2'b00} == OFS_EXT_ADDR) begin
        rdata_d = {24'h00_0000, ext_q};
      end else if ({s_axi_araddr[7:2], 2'b00} == OFS_BYTE_BUF) begin
        rdata_d = {24'h00_0000, buf_q};
      end else if ({s_axi_araddr[7:2], 2'b00} == OFS_CONTROL) begin
        rdata_d = {24'h00_0000, ctl_q};
      end else if ({s_axi_araddr[7:2], 2'b00} == OFS_STATUS) begin
        rdata_d = {24'h00_0000, stat_q};
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Bus-side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_lane_q <= w_lane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Stored bytes untouched by soft reset, since it has no path here
  i2cra_byte_reg u_own (.aclk(aclk), .aresetn(aresetn), .we(we_oa), .wdata(w_data_q),
    .value(own_q));
  i2cra_byte_reg u_ext (.aclk(aclk), .aresetn(aresetn), .we(we_xa), .wdata(w_data_q),
    .value(ext_q));
  i2cra_byte_reg u_buf (.aclk(aclk), .aresetn(aresetn), .we(we_bb), .wdata(w_data_q),
    .value(buf_q));

  i2cra_addr_match u_match (
    .own_address_reg(own_q),
    .extended_address_reg(ext_q),
    .rx_byte(addr_byte),
    .ten_bit(ten_bit),
    .match_first(m_first),
    .match_second(m_second),
    .match_gcall(m_gcall)
  );

  // Address recognition, control and status
  always_comb begin
    state_d = state_q;
    ctl_d = ctl_q;
    stat_d = stat_q;
    div_d = div_q;
    ack_d = 1'b0;
    enter_d = 1'b0;
    rd_d = rd_q;
    if (we_ctl) begin
      ctl_d = w_data_q;
    end
    if (we_div) begin
      div_d = w_data_q;
    end
    case (state_q)
      I2CRA_IDLE: begin
        if (addr_valid && addr_after_start) begin
          if (m_gcall) begin
            ack_d = 1'b1;
            enter_d = 1'b1;
            rd_d = 1'b0;
            stat_d = STAT_GCALL;
            ctl_d[CTL_EVENT] = 1'b1;
            state_d = I2CRA_SLAVE;
          end else if (m_first && ten_bit) begin
            ack_d = 1'b1;
            state_d = I2CRA_TEN_WAIT;
          end else if (m_first) begin
            ack_d = 1'b1;
            enter_d = 1'b1;
            rd_d = addr_byte[0];
            stat_d = addr_byte[0] ? STAT_SLV_RD : STAT_SLV_WR;
            ctl_d[CTL_EVENT] = 1'b1;
            state_d = I2CRA_SLAVE;
          end
        end
      end
      I2CRA_TEN_WAIT: begin
        if (addr_valid && addr_after_start) begin
          state_d = I2CRA_IDLE; // New START abandons the pending match
        end else if (addr_valid) begin
          if (m_second) begin
            ack_d = 1'b1;
            enter_d = 1'b1;
            rd_d = 1'b0;
            stat_d = STAT_SLV_WR;
            ctl_d[CTL_EVENT] = 1'b1;
            state_d = I2CRA_SLAVE;
          end else begin
            state_d = I2CRA_IDLE;
          end
        end
      end
      I2CRA_SLAVE: begin
        state_d = I2CRA_SLAVE; // Left only by soft reset or hardware reset
      end
      default: begin
        state_d = I2CRA_IDLE;
      end
    endcase
    // Soft reset wins over everything above except rd_d
    if (we_srst) begin
      state_d = I2CRA_IDLE;
      ctl_d[CTL_STOP] = 1'b0;
      ctl_d[CTL_START] = 1'b0;
      ctl_d[CTL_EVENT] = 1'b0;
      stat_d = STAT_IDLE;
      ack_d = 1'b0;
      enter_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= I2CRA_IDLE;
      ctl_q <= RST_ZERO;
      stat_q <= STAT_IDLE;
      div_q <= RST_ZERO;
      ack_q <= 1'b0;
      enter_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctl_q <= ctl_d;
      stat_q <= stat_d;
      div_q <= div_d;
      ack_q <= ack_d;
      enter_q <= enter_d;
      rd_q <= rd_d;
    end
  end

  assign addr_ack = ack_q;
  assign slave_enter = enter_q;
  assign slave_read = rd_q;
  assign irq = ctl_q[CTL_EVENT];
  assign bit_rate_divider = div_q;

  // Checks
  sequence s_ten_first;
    addr_valid && addr_after_start && ten_bit && m_first && !m_gcall && state_q == I2CRA_IDLE
      && !we_srst && !we_ctl;
  endsequence
  property p_srst_idle;
    @(posedge aclk) disable iff (!aresetn) we_srst |=> state_q == I2CRA_IDLE
      && !ctl_q[CTL_EVENT] && !ctl_q[CTL_START] && !ctl_q[CTL_STOP];
  endproperty
  a_srst_idle: assert property (p_srst_idle) else $error("soft reset missed");
  property p_srst_keep;
    @(posedge aclk) disable iff (!aresetn) we_srst |=> own_q == $past(own_q)
      && ext_q == $past(ext_q) && buf_q == $past(buf_q);
  endproperty
  a_srst_keep: assert property (p_srst_keep) else $error("soft reset hit data");
  property p_reset_vals;
    @(posedge aclk) !aresetn |=> stat_q == STAT_IDLE && ctl_q == RST_ZERO && own_q == RST_ZERO
      && ext_q == RST_ZERO && buf_q == RST_ZERO;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  property p_seven_enter;
    @(posedge aclk) disable iff (!aresetn) (addr_valid && addr_after_start && !ten_bit
      && addr_byte[7:1] == own_q[7:1] && state_q == I2CRA_IDLE && !we_srst)
      |=> slave_enter && addr_ack;
  endproperty
  a_seven_enter: assert property (p_seven_enter) else $error("7-bit match missed");
  property p_ten_quiet;
    @(posedge aclk) disable iff (!aresetn) s_ten_first |=> addr_ack && !slave_enter
      && state_q == I2CRA_TEN_WAIT && ctl_q[CTL_EVENT] == $past(ctl_q[CTL_EVENT]);
  endproperty
  a_ten_quiet: assert property (p_ten_quiet) else $error("10-bit first byte wrong");
  property p_ten_second;
    @(posedge aclk) disable iff (!aresetn) (state_q == I2CRA_TEN_WAIT && addr_valid
      && !addr_after_start && addr_byte == ext_q && !we_srst) |=> slave_enter && irq;
  endproperty
  a_ten_second: assert property (p_ten_second) else $error("10-bit second missed");
  property p_gcall;
    @(posedge aclk) disable iff (!aresetn) (state_q == I2CRA_IDLE && addr_valid
      && addr_after_start && addr_byte == GCALL_ADDR && own_q[OA_GCALL] && !we_srst)
      |=> slave_enter && stat_q == STAT_GCALL;
  endproperty
  a_gcall: assert property (p_gcall) else $error("general call missed");
  property p_prefix;
    @(posedge aclk) disable iff (!aresetn) (state_q == I2CRA_IDLE && addr_valid
      && addr_after_start && own_q[7:3] == TEN_BIT_PREFIX && addr_byte != GCALL_ADDR)
      |=> !slave_enter;
  endproperty
  a_prefix: assert property (p_prefix) else $error("10-bit mode decode wrong");
endmodule
`default_nettype wire

// ### i2cra_master_model.sv
// Behavioural two-wire master that hands address bytes to the block
`timescale 1ns/1ns
`default_nettype none
module i2cra_master_model (
  // Clock
  input wire logic aclk,
  // Address byte link
  output logic addr_valid,
  output logic addr_after_start,
  output logic [7:0] addr_byte
);
  // Idle link shows the inverted last byte, so no stale copy can match
  initial begin
    addr_valid = 1'b0;
    addr_after_start = 1'b0;
    addr_byte = 8'h5a;
  end

  // One byte for one sampling edge; first bus bit sits in bit 7
  task automatic send(input logic [7:0] b, input logic st);
    addr_valid <= 1'b1;
    addr_after_start <= st;
    addr_byte <= b;
    @(posedge aclk);
    addr_valid <= 1'b0;
    addr_after_start <= 1'b0;
    addr_byte <= ~b;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the two-wire controller register interface
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import i2cra_pkg::*;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr, addr_byte, divider;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic addr_valid, after_start, ack, enter, slv_rd, irq;
  int n_mismatch = 0;
  int n_checks = 0;

  i2cra_regs i2cra_regs_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .addr_valid(addr_valid), .addr_after_start(after_start), .addr_byte(addr_byte),
    .addr_ack(ack), .slave_enter(enter), .slave_read(slv_rd), .irq(irq),
    .bit_rate_divider(divider));

  i2cra_master_model i2cra_master_model_i (.aclk(aclk), .addr_valid(addr_valid),
    .addr_after_start(after_start), .addr_byte(addr_byte));

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // A hung handshake ends the run instead of stalling it
  task automatic tmo();
    n_mismatch++;
    $display("[ERR] %0t handshake timed out", $time);
    give_verdict();
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    if (n == 50) tmo();
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    // One idle edge so the next call never re-raises bready in this step
    @(posedge aclk);
  endtask

  // Read: data and response taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    logic ar;
    ar = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    if (n == 50) tmo();
    chk(rdata, {24'h0, ed});
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    // One idle edge so the next call never re-raises rready in this step
    @(posedge aclk);
  endtask

  // Address byte, then {ack, enter, irq} in the cycle after sampling
  task automatic adr(input logic [7:0] b, input logic st, input logic [2:0] e);
    i2cra_master_model_i.send(b, st);
    // Registered answer is still held when this edge is sampled
    @(posedge aclk);
    chk({29'h0, ack, enter, irq}, {29'h0, e});
  endtask

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_OWN_ADDR, 8'h00, RESP_OKAY);
    rd(OFS_EXT_ADDR, 8'h00, RESP_OKAY);
    rd(OFS_BYTE_BUF, 8'h00, RESP_OKAY);
    rd(OFS_CONTROL, 8'h00, RESP_OKAY);
    rd(OFS_STATUS, STAT_IDLE, RESP_OKAY);
    rd(OFS_DIVIDER, 8'h00, RESP_SLVERR);
    rd(OFS_SOFT_RST, 8'h00, RESP_SLVERR);
    wr(OFS_STATUS, 8'h11, RESP_SLVERR);
    rd(OFS_STATUS, STAT_IDLE, RESP_OKAY);
    rd(8'h00, 8'h00, RESP_SLVERR);
    wr(8'h04, 8'h33, RESP_SLVERR);
    wr(OFS_DIVIDER, 8'h37, RESP_OKAY);
    chk({24'h0, divider}, 32'h37);
    wr(OFS_BYTE_BUF, 8'h96, RESP_OKAY);
    rd(OFS_BYTE_BUF, 8'h96, RESP_OKAY);
    // Seven-bit own address 52, general call off
    wr(OFS_OWN_ADDR, 8'ha4, RESP_OKAY);
    rd(OFS_OWN_ADDR, 8'ha4, RESP_OKAY);
    adr(8'h25, 1'b1, 3'b000);
    adr(8'ha4, 1'b0, 3'b000);
    adr(8'h00, 1'b1, 3'b000);
    adr(8'ha4, 1'b1, 3'b111);
    rd(OFS_STATUS, STAT_SLV_WR, RESP_OKAY);
    wr(OFS_CONTROL, 8'h3c, RESP_OKAY);
    wr(OFS_SOFT_RST, 8'h6b, RESP_OKAY);
    rd(OFS_CONTROL, 8'h04, RESP_OKAY);
    rd(OFS_STATUS, STAT_IDLE, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_OWN_ADDR, 8'ha4, RESP_OKAY);
    rd(OFS_BYTE_BUF, 8'h96, RESP_OKAY);
    // Read direction, proving the soft reset really returned to idle
    adr(8'ha5, 1'b1, 3'b111);
    rd(OFS_STATUS, STAT_SLV_RD, RESP_OKAY);
    chk({31'h0, slv_rd}, 32'h1);
    wr(OFS_SOFT_RST, 8'h00, RESP_OKAY);
    // General call accepted
    wr(OFS_OWN_ADDR, 8'ha5, RESP_OKAY);
    adr(GCALL_ADDR, 1'b1, 3'b111);
    rd(OFS_STATUS, STAT_GCALL, RESP_OKAY);
    wr(OFS_SOFT_RST, 8'hff, RESP_OKAY);
    // Ten-bit own address 15a
    wr(OFS_OWN_ADDR, 8'hf2, RESP_OKAY);
    wr(OFS_EXT_ADDR, 8'h5a, RESP_OKAY);
    rd(OFS_EXT_ADDR, 8'h5a, RESP_OKAY);
    adr(8'hf4, 1'b1, 3'b000);
    adr(8'hf2, 1'b1, 3'b100);
    rd(OFS_STATUS, STAT_IDLE, RESP_OKAY);
    adr(8'h5a, 1'b0, 3'b111);
    rd(OFS_STATUS, STAT_SLV_WR, RESP_OKAY);
    // Once in slave operation further address bytes are ignored, flag stays
    adr(8'hf2, 1'b1, 3'b001);
    wr(OFS_SOFT_RST, 8'h00, RESP_OKAY);
    // Wrong second byte, then a fresh START, both drop the pending match
    adr(8'hf2, 1'b1, 3'b100);
    adr(8'h5b, 1'b0, 3'b000);
    adr(8'hf2, 1'b1, 3'b100);
    adr(8'hf2, 1'b1, 3'b000);
    adr(8'h5a, 1'b0, 3'b000);
    rd(OFS_EXT_ADDR, 8'h5a, RESP_OKAY);
    // Hardware reset in mid-run clears what soft reset kept
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_OWN_ADDR, 8'h00, RESP_OKAY);
    rd(OFS_EXT_ADDR, 8'h00, RESP_OKAY);
    rd(OFS_BYTE_BUF, 8'h00, RESP_OKAY);
    rd(OFS_STATUS, STAT_IDLE, RESP_OKAY);
    give_verdict();
  end
endmodule
`default_nettype wire
